/* logic/sbr_map.svh */
// widths, field positions, command codes and timing counts of the sdram controller
`ifndef SBR_MAP_SVH
`define SBR_MAP_SVH
`define SBR_DIV_W 12
`define SBR_NUM_CS 4
`define SBR_NUM_IBANK 4
`define SBR_PAGES 16
`define SBR_CS_LSB 26
`define SBR_PHYS_W 24
`define SBR_MRS_CAS_LSB 4
`define SBR_T_MRD 5'h02
`define SBR_T_RRD_ADD 6'h01
`define SBR_WAIT_W 5
`define SBR_GAP_W 6
`define SBR_CMD_MRS 3'h0
`define SBR_CMD_REF 3'h1
`define SBR_CMD_PRE 3'h2
`define SBR_CMD_ACT 3'h3
`define SBR_CMD_WR 3'h4
`define SBR_CMD_RD 3'h5
`define SBR_CMD_NOP 3'h7
`define SBR_CS_NONE 4'hf
`define SBR_CS_ALL 4'h0
`endif

/* logic/sbr_pkg.sv */
// types shared by the sdram controller files
`include "sbr_map.svh"
package sbr_pkg;
   typedef enum logic [3:0] {
      ST_UNINIT = 4'b0000,
      ST_PALL = 4'b0001,
      ST_REF = 4'b0010,
      ST_MRS = 4'b0011,
      ST_IDLE = 4'b0100,
      ST_DECIDE = 4'b0101,
      ST_PRE_ONE = 4'b0110,
      ST_ACT = 4'b0111,
      ST_RW = 4'b1000,
      ST_RD_CAP = 4'b1001,
      ST_FINISH = 4'b1010,
      ST_SR_ENT = 4'b1011,
      ST_SREF = 4'b1100
   } sbr_state_t;

   typedef struct packed {
      logic write;
      logic fetch;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sbr_req_t;

   typedef struct packed {
      logic enable;
      logic init_start;
      logic sref_req;
      logic sixteen_bit_packing_enable;
      logic address_map_mode;
      logic [`SBR_DIV_W-1:0] refresh_divisor;
      logic [3:0] t_ras;
      logic [2:0] t_rp;
      logic [2:0] t_rcd;
      logic [2:0] cas_lat;
   } sbr_cfg_t;

   typedef struct packed {
      logic cke;
      logic [`SBR_NUM_CS-1:0] external_chip_selects_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic a10;
      logic [15:0] addr;
      logic [1:0] internal_bank_select_lines;
      logic data_mask_out;
      logic dq_oe;
      logic [15:0] dq;
   } sbr_pins_t;
endpackage

/* logic/sbr_sync.sv */
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module sbr_sync #(
   parameter int W = 1 // bundle width
) (
   input wire logic clk_i, // destination clock
   input wire logic rst_i, // async reset, active high
   input wire logic [W-1:0] d_i, // level from another domain
   output logic [W-1:0] q_o // synchronised level
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // first flop feeds only the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule

/* logic/sbr_ctrl.sv */
// sdram command sequencer with refresh, open-page tracking and address packing
//
// Contract
// - refresh time-out every divisor sdram cycles
// - precharge-all before every auto-refresh
// - refresh spacing uses ras plus rp
// - one open page per internal bank
// - activate first on closed bank
// - other banks stay open, up to sixteen
// - activates to different banks: rcd plus one
// - page miss precharges only that bank
// - sixteen pages tracked over four selects
// - bank on bank lines, device on selects
// - packing: one logical word, two physical
// - map mode picks bank or page interleave
// - two cycles after mode register set
// - same bank activates spaced ras plus rp
// - after refresh wait ras plus rp
// - after self-refresh exit wait ras plus rp
// - mask high until init, then low
// - hard or soft reset uninitialises controller
// - running reset leaves controller untouched
// - bank logical ranges map to 24-bit physical
// - instruction fetch only from select zero
// - code address is one 32-bit word
`timescale 1ns/1ps
`include "sbr_map.svh"
module sbr_ctrl #(
   parameter int COL_W = 9, // column address bits
   parameter int ROW_W = 12 // row address bits
) (
   input wire logic core_clk_i, // core clock
   input wire logic sdram_clk_i, // sdram clock, link side
   input wire logic rst_i, // hard reset, async, active high
   input wire logic soft_rst_i, // soft reset level, any domain
   input wire sbr_pkg::sbr_cfg_t cfg_i, // quasi-static configuration
   input wire logic req_valid_i, // request offered
   output logic req_ready_o, // request can be taken
   input wire sbr_pkg::sbr_req_t req_i, // request fields
   output logic rsp_valid_o, // one-cycle answer pulse
   output logic rsp_err_o, // request refused
   output logic [31:0] rsp_rdata_o, // read data
   output logic init_done_o, // sdram initialised
   output sbr_pkg::sbr_pins_t pins_o, // sdram pins
   input wire logic [15:0] dq_i // sdram data in
);
   import sbr_pkg::*;

   localparam int SW = $bits(sbr_cfg_t) + 2;

   // core domain state
   logic ready_reg;
   logic rsp_vld_reg;
   logic rsp_err_reg;
   logic [31:0] rsp_rdata_reg;
   logic req_tgl_reg;
   logic ack_seen_reg;
   sbr_req_t hold_reg;
   logic [1:0] core_q;

   // sdram domain state
   logic [SW-1:0] sd_q;
   sbr_cfg_t cfg_q;
   logic soft_q;
   logic req_q;
   sbr_state_t st_reg;
   logic [`SBR_WAIT_W-1:0] wait_reg;
   logic [`SBR_GAP_W-1:0] gap_reg;
   logic [3:0] last_idx_reg;
   logic [3:0] cur_idx_reg;
   logic [ROW_W-1:0] cur_row_reg;
   logic [COL_W-1:0] cur_col_reg;
   logic half_reg;
   logic busy_reg;
   logic err_reg;
   logic sr_go_reg;
   logic init_done_reg;
   logic req_seen_reg;
   logic ack_tgl_reg;
   logic [31:0] rdata_reg;
   sbr_pins_t pins_reg;
   logic [`SBR_DIV_W-1:0] ref_cnt_reg;
   logic ref_pend_reg;
   logic ref_take;
   logic [`SBR_PAGES-1:0] open_vld_reg;
   logic [ROW_W-1:0] open_row_reg [`SBR_PAGES];

   // address decode of the current half
   logic [`SBR_PHYS_W-1:0] phys;
   logic [COL_W-1:0] m_col;
   logic [ROW_W-1:0] m_row;
   logic [1:0] m_bank;
   logic [1:0] m_cs;
   logic [3:0] m_idx;
   logic [`SBR_WAIT_W-1:0] trc;
   logic [`SBR_GAP_W-1:0] gap_need;
   logic new_req;

   // logical word to 24-bit physical address of one half
   function automatic logic [`SBR_PHYS_W-1:0] phys_of(input logic [31:0] a,
                                                       input logic h,
                                                       input logic pk);
      return pk ? {a[22:0], h} : a[23:0];
   endfunction

   // active-low select for one chip select
   function automatic logic [`SBR_NUM_CS-1:0] cs_n_of(input logic [1:0] c);
      return ~(4'h1 << c);
   endfunction

   // page table slot for chip select and internal bank
   function automatic logic [3:0] idx_of(input logic [1:0] c, input logic [1:0] b);
      return {c, b};
   endfunction

   assign phys = phys_of(hold_reg.addr, half_reg, cfg_q.sixteen_bit_packing_enable);
   assign m_col = phys[COL_W-1:0];
   assign m_row = cfg_q.address_map_mode ? phys[COL_W+2 +: ROW_W] : phys[COL_W +: ROW_W];
   assign m_bank = cfg_q.address_map_mode ? phys[COL_W +: 2] : phys[COL_W+ROW_W +: 2];
   assign m_cs = hold_reg.addr[`SBR_CS_LSB +: 2];
   assign m_idx = idx_of(m_cs, m_bank);

   assign trc = `SBR_WAIT_W'(cfg_q.t_ras) + `SBR_WAIT_W'(cfg_q.t_rp);
   assign gap_need = (last_idx_reg == cur_idx_reg) ? `SBR_GAP_W'(trc) :
                     `SBR_GAP_W'(cfg_q.t_rcd) + `SBR_T_RRD_ADD;
   assign new_req = (req_q != req_seen_reg);
   assign ref_take = (st_reg == ST_IDLE) && (wait_reg == '0) && ref_pend_reg && !soft_q;

   // core side: hold one request, toggle it across, wait for the answer
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_reg <= 1'b1;
         rsp_vld_reg <= 1'b0;
         rsp_err_reg <= 1'b0;
         rsp_rdata_reg <= 32'h0000_0000;
         req_tgl_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
         hold_reg <= '0;
      end else begin
         rsp_vld_reg <= 1'b0;
         if (req_valid_i && ready_reg) begin
            hold_reg <= req_i;
            req_tgl_reg <= ~req_tgl_reg;
            ready_reg <= 1'b0;
         end else if (core_q[1] != ack_seen_reg) begin
            ack_seen_reg <= core_q[1];
            rsp_vld_reg <= 1'b1;
            rsp_err_reg <= err_reg; // stable since the ack toggle
            rsp_rdata_reg <= rdata_reg;
            ready_reg <= 1'b1;
         end
      end
   end

   // ack toggle and init status into the core domain
   sbr_sync #(
      .W(2)
   ) u_core_sync (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .d_i({ack_tgl_reg, init_done_reg}),
      .q_o(core_q)
   );

   // request toggle, soft reset and configuration into the sdram domain
   sbr_sync #(
      .W(SW)
   ) u_sd_sync (
      .clk_i(sdram_clk_i),
      .rst_i(rst_i),
      .d_i({req_tgl_reg, soft_rst_i, cfg_i}),
      .q_o(sd_q)
   );
   assign req_q = sd_q[SW-1];
   assign soft_q = sd_q[SW-2];
   assign cfg_q = sd_q[SW-3:0];

   // refresh counter and sticky refresh request
   always_ff @(posedge sdram_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_cnt_reg <= '0;
         ref_pend_reg <= 1'b0;
      end else if (soft_q || !init_done_reg || !cfg_q.enable) begin
         ref_cnt_reg <= cfg_q.refresh_divisor - `SBR_DIV_W'(1);
         ref_pend_reg <= 1'b0;
      end else begin
         if (ref_cnt_reg == '0) begin
            ref_cnt_reg <= cfg_q.refresh_divisor - `SBR_DIV_W'(1);
         end else begin
            ref_cnt_reg <= ref_cnt_reg - `SBR_DIV_W'(1);
         end
         if (ref_cnt_reg == '0) begin
            ref_pend_reg <= 1'b1;
         end else if (ref_take) begin
            ref_pend_reg <= 1'b0;
         end
      end
   end

   // open-page valid bits, follow the registered commands
   always_ff @(posedge sdram_clk_i or posedge rst_i) begin
      if (rst_i) begin
         open_vld_reg <= '0;
      end else if (soft_q) begin
         open_vld_reg <= '0;
      end else if ({pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} == `SBR_CMD_PRE &&
                   pins_reg.external_chip_selects_n != `SBR_CS_NONE) begin
         if (pins_reg.a10) begin
            open_vld_reg <= '0;
         end else begin
            open_vld_reg[cur_idx_reg] <= 1'b0;
         end
      end else if ({pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} == `SBR_CMD_ACT &&
                   pins_reg.external_chip_selects_n != `SBR_CS_NONE) begin
         open_vld_reg[cur_idx_reg] <= 1'b1;
      end
   end

   // open row per slot, valid bits tell whether it is meaningful
   always_ff @(posedge sdram_clk_i) begin
      if (st_reg == ST_ACT && wait_reg == '0 && gap_reg >= gap_need) begin
         open_row_reg[cur_idx_reg] <= cur_row_reg;
      end
   end

   // command sequencer, pins and timing
   always_ff @(posedge sdram_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= ST_UNINIT;
         wait_reg <= '0;
         gap_reg <= '1;
         last_idx_reg <= 4'h0;
         cur_idx_reg <= 4'h0;
         cur_row_reg <= '0;
         cur_col_reg <= '0;
         half_reg <= 1'b0;
         busy_reg <= 1'b0;
         err_reg <= 1'b0;
         sr_go_reg <= 1'b0;
         init_done_reg <= 1'b0;
         req_seen_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         pins_reg <= '0;
         pins_reg.cke <= 1'b1;
         pins_reg.external_chip_selects_n <= `SBR_CS_NONE;
         {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_NOP;
         pins_reg.data_mask_out <= 1'b1;
      end else begin
         // idle pins unless a command is issued below
         pins_reg.external_chip_selects_n <= `SBR_CS_NONE;
         {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_NOP;
         pins_reg.a10 <= 1'b0;
         pins_reg.dq_oe <= 1'b0;
         pins_reg.data_mask_out <= ~init_done_reg;
         if (gap_reg != '1) begin
            gap_reg <= gap_reg + `SBR_GAP_W'(1);
         end
         // only hard or soft reset clears
         if (soft_q) begin
            st_reg <= busy_reg ? ST_FINISH : ST_UNINIT;
            err_reg <= busy_reg;
            init_done_reg <= 1'b0;
            wait_reg <= '0;
            sr_go_reg <= 1'b0;
            pins_reg.cke <= 1'b1;
         end else if (wait_reg != '0) begin
            wait_reg <= wait_reg - `SBR_WAIT_W'(1);
         end else begin
            case (st_reg)
               ST_UNINIT: begin
                  if (new_req) begin
                     req_seen_reg <= req_q;
                     busy_reg <= 1'b1;
                     err_reg <= 1'b1; // no access before initialisation
                     st_reg <= ST_FINISH;
                  end else if (cfg_q.enable && cfg_q.init_start) begin
                     st_reg <= ST_PALL;
                  end
               end
               ST_IDLE: begin
                  if (ref_pend_reg) begin
                     st_reg <= ST_PALL;
                  end else if (cfg_q.sref_req) begin
                     sr_go_reg <= 1'b1;
                     st_reg <= ST_PALL;
                  end else if (new_req) begin
                     req_seen_reg <= req_q;
                     busy_reg <= 1'b1;
                     half_reg <= 1'b0;
                     rdata_reg <= 32'h0000_0000;
                     err_reg <= hold_reg.fetch && (m_cs != 2'h0);
                     st_reg <= (hold_reg.fetch && (m_cs != 2'h0)) ? ST_FINISH : ST_DECIDE;
                  end
               end
               ST_DECIDE: begin
                  cur_idx_reg <= m_idx;
                  cur_row_reg <= m_row;
                  cur_col_reg <= m_col;
                  if (open_vld_reg[m_idx] && open_row_reg[m_idx] == m_row) begin
                     st_reg <= ST_RW;
                  end else if (open_vld_reg[m_idx]) begin
                     st_reg <= ST_PRE_ONE;
                  end else begin
                     st_reg <= ST_ACT;
                  end
               end
               ST_PRE_ONE: begin
                  pins_reg.external_chip_selects_n <= cs_n_of(cur_idx_reg[3:2]);
                  {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_PRE;
                  pins_reg.internal_bank_select_lines <= cur_idx_reg[1:0];
                  wait_reg <= `SBR_WAIT_W'(cfg_q.t_rp) - `SBR_WAIT_W'(1);
                  st_reg <= ST_ACT;
               end
               ST_ACT: begin
                  if (gap_reg >= gap_need) begin
                     pins_reg.external_chip_selects_n <= cs_n_of(cur_idx_reg[3:2]);
                     pins_reg.internal_bank_select_lines <= cur_idx_reg[1:0];
                     {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_ACT;
                     pins_reg.addr <= 16'(cur_row_reg);
                     pins_reg.a10 <= cur_row_reg[10];
                     gap_reg <= `SBR_GAP_W'(1);
                     last_idx_reg <= cur_idx_reg;
                     wait_reg <= `SBR_WAIT_W'(cfg_q.t_rcd) - `SBR_WAIT_W'(1);
                     st_reg <= ST_RW;
                  end
               end
               ST_RW: begin
                  pins_reg.external_chip_selects_n <= cs_n_of(cur_idx_reg[3:2]);
                  pins_reg.internal_bank_select_lines <= cur_idx_reg[1:0];
                  pins_reg.addr <= 16'(cur_col_reg);
                  if (hold_reg.write) begin
                     {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_WR;
                     pins_reg.dq_oe <= 1'b1;
                     pins_reg.dq <= half_reg ? hold_reg.wdata[31:16] : hold_reg.wdata[15:0];
                     if (cfg_q.sixteen_bit_packing_enable && !half_reg) begin
                        half_reg <= 1'b1;
                        st_reg <= ST_DECIDE;
                     end else begin
                        st_reg <= ST_FINISH;
                     end
                  end else begin
                     {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_RD;
                     wait_reg <= `SBR_WAIT_W'(cfg_q.cas_lat);
                     st_reg <= ST_RD_CAP;
                  end
               end
               ST_RD_CAP: begin
                  if (half_reg) begin
                     rdata_reg[31:16] <= dq_i;
                  end else begin
                     rdata_reg[15:0] <= dq_i;
                  end
                  if (cfg_q.sixteen_bit_packing_enable && !half_reg) begin
                     half_reg <= 1'b1;
                     st_reg <= ST_DECIDE;
                  end else begin
                     st_reg <= ST_FINISH;
                  end
               end
               ST_FINISH: begin
                  ack_tgl_reg <= ~ack_tgl_reg;
                  busy_reg <= 1'b0;
                  st_reg <= init_done_reg ? ST_IDLE : ST_UNINIT;
               end
               ST_PALL: begin
                  // close every bank on every select
                  pins_reg.external_chip_selects_n <= `SBR_CS_ALL;
                  {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_PRE;
                  pins_reg.a10 <= 1'b1;
                  wait_reg <= `SBR_WAIT_W'(cfg_q.t_rp) - `SBR_WAIT_W'(1);
                  st_reg <= sr_go_reg ? ST_SR_ENT : ST_REF;
               end
               ST_REF: begin
                  pins_reg.external_chip_selects_n <= `SBR_CS_ALL;
                  {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_REF;
                  wait_reg <= trc - `SBR_WAIT_W'(1);
                  gap_reg <= '1;
                  st_reg <= init_done_reg ? ST_IDLE : ST_MRS;
               end
               ST_MRS: begin
                  pins_reg.external_chip_selects_n <= `SBR_CS_ALL;
                  {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_MRS;
                  pins_reg.addr <= 16'(cfg_q.cas_lat) << `SBR_MRS_CAS_LSB;
                  wait_reg <= `SBR_T_MRD - `SBR_WAIT_W'(1);
                  init_done_reg <= 1'b1;
                  st_reg <= ST_IDLE;
               end
               ST_SR_ENT: begin
                  pins_reg.external_chip_selects_n <= `SBR_CS_ALL;
                  {pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} <= `SBR_CMD_REF;
                  pins_reg.cke <= 1'b0;
                  st_reg <= ST_SREF;
               end
               ST_SREF: begin
                  if (!cfg_q.sref_req) begin
                     pins_reg.cke <= 1'b1;
                     // exit delay is row cycle time
                     wait_reg <= trc - `SBR_WAIT_W'(1);
                     gap_reg <= '1;
                     sr_go_reg <= 1'b0;
                     st_reg <= ST_IDLE;
                  end
               end
               default: begin
                  st_reg <= ST_UNINIT;
               end
            endcase
         end
      end
   end

   // outputs straight from flops
   assign req_ready_o = ready_reg;
   assign rsp_valid_o = rsp_vld_reg;
   assign rsp_err_o = rsp_err_reg;
   assign rsp_rdata_o = rsp_rdata_reg;
   assign init_done_o = core_q[0];
   assign pins_o = pins_reg;
endmodule

/* verif/sbr_ctrl_checker.sv */
// port assertions for the sdram controller
`timescale 1ns/1ps
module sbr_ctrl_checker (
   input wire logic core_clk_i, // core clock
   input wire logic sdram_clk_i, // sdram clock
   input wire logic rst_i, // hard reset
   input wire sbr_pkg::sbr_cfg_t cfg_i, // settings
   input wire logic req_valid_i, // request
   input wire logic req_ready_o, // ready
   input wire logic rsp_valid_o, // answer
   input wire logic rsp_err_o, // refused
   input wire logic init_done_o, // ready for use
   input wire sbr_pkg::sbr_pins_t pins_o // sdram pins
);
   import sbr_pkg::*;
   logic [7:0] s_act, s_ref, s_pre;
   logic [5:0] slot;
   logic pall;
   wire [3:0] sel = pins_o.external_chip_selects_n;
   wire [2:0] cmd = {pins_o.ras_n, pins_o.cas_n, pins_o.we_n};
   wire on = pins_o.cke && sel != 4'hf && cmd != 3'h7;
   wire [5:0] here = {sel, pins_o.internal_bank_select_lines};
   wire act = on && cmd == 3'h3;
   wire rfs = on && cmd == 3'h1;
   wire [7:0] trc = cfg_i.t_ras + cfg_i.t_rp;
   // cycles since last act, ref, pre
   always_ff @(posedge sdram_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_act <= 8'hff;
         s_ref <= 8'hff;
         s_pre <= 8'hff;
         slot <= 6'h3f;
      end else begin
         s_act <= act ? 8'h01 : s_act + 8'(s_act != 8'hff);
         s_ref <= rfs ? 8'h01 : s_ref + 8'(s_ref != 8'hff);
         s_pre <= (on && cmd == 3'h2) ? 8'h01 : s_pre + 8'(s_pre != 8'hff);
         if (act) slot <= here;
      end
   end
   // last command closed all banks
   always_ff @(posedge sdram_clk_i or posedge rst_i) begin
      if (rst_i) pall <= 1'b0;
      else if (on) pall <= cmd == 3'h2 && pins_o.a10;
   end
   a_act_other_bank: assert property (@(posedge sdram_clk_i) disable iff (rst_i)
      act && here != slot |-> s_act > cfg_i.t_rcd) else $error("act other bank early");
   a_act_same_bank: assert property (@(posedge sdram_clk_i) disable iff (rst_i)
      act && here == slot |-> s_act >= trc) else $error("act same bank early");
   a_ref_to_act: assert property (@(posedge sdram_clk_i) disable iff (rst_i)
      act |-> s_ref >= trc) else $error("act after refresh early");
   a_pall_then_ref: assert property (@(posedge sdram_clk_i) disable iff (rst_i)
      rfs |-> pall && s_pre >= cfg_i.t_rp) else $error("refresh w/o pall");
   a_mrs_quiet: assert property (@(posedge sdram_clk_i) disable iff (rst_i)
      on && cmd == 3'h0 |=> !on) else $error("cmd after mode set");
   a_mask_low: assert property (@(posedge sdram_clk_i) disable iff (rst_i)
      $fell(pins_o.data_mask_out) |=> !pins_o.data_mask_out [*8]) else $error("mask rose");
   a_err_uninit: assert property (@(posedge core_clk_i) disable iff (rst_i)
      rsp_valid_o && !init_done_o |-> rsp_err_o) else $error("answer before init");
   a_ready_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
      req_valid_i && req_ready_o |=> !req_ready_o ##1 !rsp_valid_o) else $error("ready held");
   c_other: cover property (@(posedge sdram_clk_i) act && here != slot);
   c_ref: cover property (@(posedge sdram_clk_i) rfs);
   c_err: cover property (@(posedge core_clk_i) rsp_valid_o && rsp_err_o);
endmodule

/* verif/sbr_sdram_model.sv */
// behavioural sdram, 4 selects of 4 banks
`timescale 1ns/1ps
module sbr_sdram_model (
   input wire logic clk_i, // sdram clock
   input wire sbr_pkg::sbr_pins_t pins_i, // controller pins
   output logic [15:0] dq_o, // read data
   output logic [7:0] errs_o // protocol faults
);
   import sbr_pkg::*;
   logic [15:0] mem [logic [37:0]];
   logic [15:0] row_reg [64];
   logic [63:0] open_reg = 64'h0;
   logic [2:0] cl_reg = 3'h2;
   logic [5:0] s;
   logic [37:0] k;
   initial dq_o = 16'h0;
   initial errs_o = 8'h0;
   // decode one command per edge
   always @(posedge clk_i) begin
      s = {pins_i.external_chip_selects_n, pins_i.internal_bank_select_lines};
      k = {s, row_reg[s], pins_i.addr};
      if (pins_i.cke && pins_i.external_chip_selects_n != 4'hf) begin
         case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
            3'h0: cl_reg = pins_i.addr[6:4];
            3'h3: begin
               if (open_reg[s]) errs_o++;
               open_reg[s] = 1'b1;
               row_reg[s] = pins_i.addr;
            end
            3'h2: begin
               if (pins_i.a10) open_reg = 64'h0;
               else open_reg[s] = 1'b0;
            end
            3'h1: if (open_reg != 64'h0) errs_o++;
            3'h4: begin
               if (!open_reg[s] || !pins_i.dq_oe) errs_o++;
               mem[k] = pins_i.dq;
            end
            3'h5: begin
               if (!open_reg[s]) errs_o++;
               fork
                  automatic logic [15:0] v = mem.exists(k) ? mem[k] : ~k[15:0];
                  automatic int n = cl_reg;
                  begin
                     repeat (n - 1) @(posedge clk_i);
                     dq_o <= v;
                     @(posedge clk_i);
                     dq_o <= ~v;
                  end
               join_none
            end
            default: ;
         endcase
      end
   end
endmodule

/* verif/tb.sv */
// self-checking bench for the sdram controller
`timescale 1ns/1ps
bind sbr_ctrl sbr_ctrl_checker CHK (.core_clk_i(core_clk_i), .sdram_clk_i(sdram_clk_i),
   .rst_i(rst_i), .cfg_i(cfg_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
   .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o), .init_done_o(init_done_o),
   .pins_o(pins_o));
module tb;
   import sbr_pkg::*;
   logic core_clk_i = 1'b0, sdram_clk_i = 1'b0, rst_i = 1'b1, soft_rst_i = 1'b0;
   logic req_valid_i = 1'b0, req_ready_o, rsp_valid_o, rsp_err_o, init_done_o;
   logic [31:0] rsp_rdata_o, seed = 32'hc99f, a [8], mem [logic [31:0]];
   logic [15:0] dq_i;
   logic [7:0] errs;
   logic [33:0] e, exp_q [$];
   sbr_cfg_t cfg_i = '0;
   sbr_req_t req_i = '0;
   sbr_pins_t pins_o;
   int failures = 0, checks_done = 0, refs = 0;
   always #5 core_clk_i = ~core_clk_i;
   always #15 sdram_clk_i <= #3.7 ~sdram_clk_i;
   sbr_ctrl DUT (.core_clk_i(core_clk_i), .sdram_clk_i(sdram_clk_i), .rst_i(rst_i),
      .soft_rst_i(soft_rst_i), .cfg_i(cfg_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
      .rsp_err_o(rsp_err_o), .rsp_rdata_o(rsp_rdata_o), .init_done_o(init_done_o),
      .pins_o(pins_o), .dq_i(dq_i));
   sbr_sdram_model MEM (.clk_i(sdram_clk_i), .pins_i(pins_o), .dq_o(dq_i), .errs_o(errs));
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      checks_done++;
      if (seen !== want) begin
         failures++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic results;
      if (failures == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   // one request, then await its answer
   task automatic xfer(input logic w, f, input logic [31:0] ad, d, input logic [33:0] x);
      int n;
      @(posedge core_clk_i);
      req_valid_i <= 1'b1;
      req_i <= '{w, f, ad, d};
      exp_q.push_back(x);
      for (n = 0; n < 500 && req_ready_o !== 1'b1; n++) @(negedge core_clk_i);
      @(posedge core_clk_i);
      req_valid_i <= 1'b0;
      for (n = 0; n < 500 && exp_q.size() != 0; n++) @(negedge core_clk_i);
      if (n == 500) begin
         failures++;
         results();
      end
   endtask
   // match answers to oldest note
   always @(negedge core_clk_i) begin
      if (rsp_valid_o === 1'b1) begin
         e = exp_q.size() != 0 ? exp_q.pop_front() : 34'h0_ffff_ffff;
         check({rsp_err_o, e[33] ? rsp_rdata_o : 32'h0}, e[32:0]);
      end
   end
   // count refresh commands
   always @(negedge sdram_clk_i) begin
      if (pins_o.cke && pins_o.external_chip_selects_n != 4'hf &&
          {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} == 3'h1) refs++;
   end
   // main sequence
   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      xfer(1'b0, 1'b0, 32'h0, 32'h0, 34'h1_0000_0000);
      cfg_i <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 12'h0c8, 4'h4, 3'h2, 3'h2, 3'h2};
      for (int n = 0; n < 3000 && init_done_o !== 1'b1; n++) @(negedge core_clk_i);
      check({32'h0, init_done_o}, 33'h1);
      for (int m = 0; m < 4; m++) begin
         cfg_i.sixteen_bit_packing_enable <= m[0];
         cfg_i.address_map_mode <= m[1];
         repeat (20) @(posedge core_clk_i);
         for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            a[i] = i[0] ? a[i - 1] ^ 32'h1000 : seed & 32'h0c7f_ffff;
            seed = xs(seed);
            mem[a[i]] = m[0] ? seed : {16'h0, seed[15:0]};
            xfer(1'b1, 1'b0, a[i], seed, 34'h0);
         end
         for (int i = 7; i >= 0; i--) begin
            xfer(1'b0, a[i][27:26] == 2'h0, a[i], 32'h0, {2'b10, mem[a[i]]});
         end
         check({30'h0, pins_o.data_mask_out, pins_o.internal_bank_select_lines},
               {31'h0, a[0][(m[1] ? 9 : 21) - m[0] +: 2]});
      end
      cfg_i.sref_req <= 1'b1;
      repeat (40) @(posedge core_clk_i);
      cfg_i.sref_req <= 1'b0;
      xfer(1'b0, 1'b1, 32'h0800_0000, 32'h0, 34'h1_0000_0000);
      refs = 0;
      repeat (600) @(posedge sdram_clk_i);
      check({32'h0, refs >= 2 && refs <= 4}, 33'h1);
      @(posedge core_clk_i);
      cfg_i.init_start <= 1'b0;
      soft_rst_i <= 1'b1;
      repeat (12) @(posedge core_clk_i);
      soft_rst_i <= 1'b0;
      repeat (20) @(posedge core_clk_i);
      check({31'h0, init_done_o, pins_o.data_mask_out}, 33'h1);
      xfer(1'b0, 1'b0, 32'h0, 32'h0, 34'h1_0000_0000);
      check({25'h0, errs}, 33'h0);
      results();
   end
   // cut a hang short
   initial begin
      #800_000;
      failures++;
      results();
   end
endmodule
